// ---- rtl/rsp_params.svh ----
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH

// widths of the configuration word and result packets
`define RSP_WORD_BITS   12
`define RSP_CODE_BITS   3
`define RSP_CHANNELS    4
`define RSP_RESULT_BITS 16
`define RSP_PKT_BITS    24
`define RSP_PKT_LAST    5'h17
`define RSP_WORD_LAST   4'hB

// reset value of the range register: code 7 on every channel
`define RSP_CFG_RESET   12'hFFF

// clock rate and times
`define RSP_CLK_MHZ     50
`define RSP_STARTUP_US  10000
`define RSP_CONV_BASE_NS 500
`define RSP_CONV_CH_NS  600

// depth of the word buffer in the configuration path
`define RSP_BUF_DEPTH   2

`endif

// ---- rtl/rsp_pkg.sv ----
package rsp_pkg;

    // phase of the conversion cycle as seen by the serial port
    typedef enum logic [1:0] {
        PH_STARTUP,
        PH_WINDOW,
        PH_CONVERT
    } rsp_phase_t;

    // state of the serial port, apart from its word buffer
    typedef struct packed {
        logic        clk_s1;
        logic        clk_s2;
        logic        clk_d;
        logic        cfg_s1;
        logic        cfg_s2;
        logic        cs_s1;
        logic        cs_s2;
        logic        cnv_s1;
        logic        cnv_s2;
        logic        cnv_d;
        logic        mode_s1;
        logic        mode_s2;
        rsp_phase_t  phase;
        logic [19:0] timer;
        logic [11:0] range_cfg;
        logic [11:0] conv_range;
        logic [3:0]  ch_en;
        logic [11:0] shreg;
        logic [3:0]  bit_cnt;
        logic        word_pend;
        logic [11:0] word;
        logic [63:0] results;
        logic [4:0]  out_bit;
        logic [1:0]  out_ch;
        logic        result_serial_out;
        logic        sdo_oe;
        logic        echo;
        logic        echo_oe;
        logic        busy;
        logic        win;
    } rsp_state_t;

endpackage : rsp_pkg

// ---- rtl/rsp_pair_buffer.sv ----
`timescale 1ns/1ns
`include "rsp_params.svh"

module rsp_pair_buffer
    import rsp_pkg::*;
#(
    parameter int WIDTH = `RSP_WORD_BITS,
    parameter int DEPTH = `RSP_BUF_DEPTH
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // draining side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd;
        logic [PW-1:0]               wr;
        logic [PW:0]                 cnt;
    } rsp_buf_t;

    rsp_buf_t s;
    rsp_buf_t next_s;
    logic     push;
    logic     pop;

    // full and empty come straight from the occupancy count
    assign o_in_ready  = (s.cnt != (PW+1)'(DEPTH));
    assign o_out_valid = (s.cnt != '0);
    assign o_out_data  = s.mem[s.rd];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // pointer and count update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = i_in_data;
            next_s.wr = (s.wr == PW'(DEPTH-1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == PW'(DEPTH-1)) ? '0 : s.rd + 1'b1;
        end
        next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : rsp_pair_buffer

// ---- rtl/rsp_serial_port.sv ----
`timescale 1ns/1ns
`include "rsp_params.svh"

// Behaviour
// R1: range register is 12 bits, resets to all ones (code 7 everywhere).
// R2: words accepted only inside a window; they apply to the next conversion.
// R3: code 000 disables a channel and shortens the next conversion.
// R4: CMOS: fewer than 12 rising edges in a window leaves register unchanged.
// R5: CMOS: the 12th rising edge completes a word that loads the register.
// R6: an all-zero word is never loaded.
// R7: every further full 12-bit group is a new word; trailing bits dropped.
// R8: host sends word in first 12 clocks; register overwritten after 12th.
// R9: host keeps config input low after an update or for no update.
// R10: window opens 10 ms after reset and whenever busy falls.
// R11: host ends each transaction 20 ns before the next conversion.
// R12: reading after conversion start is allowed but hurts accuracy.
// R13: LVDS: output loaded with newest result, channel 0 first, as busy falls.
// R14: LVDS: one bit per clock edge, input clock echoed with the data.
// R15: host should capture LVDS data on the echoed clock edges.
// R16: LVDS: config input sampled on both clock edges.
// R17: outputs driven only while chip select is low.
// R18: LVDS: host idles the shift clock low, also around chip select.
// R19: packet is 16-bit result, three zeros, 2-bit channel, 3-bit code.
// R20: packets go channel 0,1,2,3 and wrap for as long as clocking lasts.
// R21: host captures 48 double-edge cycles per window for full rate.
// R22: shift clock up to 250 MHz must work; the 50 MHz sampler here only resolves slow bench clocks.
// R23: CMOS: config input sampled on rising edges only.
// R24: channel n takes its code from word bits 3n+2 down to 3n.
// R25: received-bit counter cleared whenever a window opens.
module rsp_serial_port
    import rsp_pkg::*;
#(
    parameter int STARTUP_CYCLES = `RSP_STARTUP_US * `RSP_CLK_MHZ,
    parameter int CONV_BASE_NS   = `RSP_CONV_BASE_NS,
    parameter int CONV_CH_NS     = `RSP_CONV_CH_NS
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // link pins from the host
    input  wire logic        i_input_shift_clock,
    input  wire logic        i_config_serial_in,
    input  wire logic        i_cs_n,
    input  wire logic        i_conv_start,
    input  wire logic        i_lvds_mode,
    // link pins to the host
    output logic             o_result_serial_out,
    output logic             o_result_serial_oe,
    output logic             o_echoed_clock_out,
    output logic             o_echoed_clock_oe,
    output logic             o_busy,
    // converter core
    input  wire logic [63:0] i_results,
    output logic [11:0]      o_input_range_select,
    output logic [3:0]       o_ch_enable,
    output logic             o_window_open
);

    // conversion time derived from the clock rate, rounded up
    localparam int BASE_CYC = (CONV_BASE_NS * `RSP_CLK_MHZ + 999) / 1000;
    localparam int CH_CYC   = (CONV_CH_NS * `RSP_CLK_MHZ + 999) / 1000;

    rsp_state_t s;
    rsp_state_t next_s;

    logic        rise;
    logic        fall;
    logic        cnv_edge;
    logic        cfg_edge;
    logic        out_edge;
    logic        buf_ready;
    logic        pop_valid;
    logic [11:0] pop_data;
    logic        pop_ready;
    logic [11:0] word_now;

    // conversion length grows with the number of enabled channels
    function automatic logic [19:0] conv_cycles(input logic [3:0] en);
        logic [19:0] n;
        n = 20'(BASE_CYC);
        for (int i = 0; i < `RSP_CHANNELS; i++) begin
            if (en[i]) begin
                n = n + 20'(CH_CYC);
            end
        end
        return n;
    endfunction : conv_cycles

    // one packet bit: result, three zeros, channel id, range code
    function automatic logic pkt_bit(input logic [63:0] res,
                                     input logic [1:0]  ch,
                                     input logic [11:0] rng,
                                     input logic [4:0]  bitn);
        logic [23:0] p;
        p = {res[16*ch +: 16], 3'h0, ch, rng[3*ch +: 3]};  // R19 R24
        return p[bitn];
    endfunction : pkt_bit

    // channel enables from the range codes, code 000 is off
    function automatic logic [3:0] enables(input logic [11:0] rng);
        logic [3:0] e;
        for (int i = 0; i < `RSP_CHANNELS; i++) begin
            e[i] = (rng[3*i +: 3] != 3'h0);  // R3 R24
        end
        return e;
    endfunction : enables

    // edges seen on the synchronised shift clock; the 50 MHz sampler only
    // resolves slow bench clocks, a real 250 MHz link needs a fast capture
    assign rise     = s.clk_s2 & ~s.clk_d;  // R22
    assign fall     = ~s.clk_s2 & s.clk_d;
    assign cnv_edge = s.cnv_s2 & ~s.cnv_d;
    // config sampled rising only in CMOS, both edges in LVDS
    assign cfg_edge = s.win & ~s.cs_s2
                    & (rise | (s.mode_s2 & fall));  // R2 R16 R23
    // output moves on every edge in LVDS, rising only in CMOS
    assign out_edge = ~s.cs_s2 & (rise | (s.mode_s2 & fall));  // R14 R12
    assign word_now = {s.shreg[10:0], s.cfg_s2};
    // hold the drain while a conversion launches so its range is settled
    assign pop_ready = ~cnv_edge;

    rsp_pair_buffer #(
        .WIDTH (`RSP_WORD_BITS),
        .DEPTH (`RSP_BUF_DEPTH)
    ) u_word_buf (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (s.word_pend),
        .i_in_data   (s.word),
        .o_in_ready  (buf_ready),
        .o_out_valid (pop_valid),
        .o_out_data  (pop_data),
        .i_out_ready (pop_ready)
    );

    // next state of the whole port
    always_comb begin
        next_s = s;
        // two-flop synchronisers for every pin from the host
        next_s.clk_s1  = i_input_shift_clock;
        next_s.clk_s2  = s.clk_s1;
        next_s.clk_d   = s.clk_s2;
        next_s.cfg_s1  = i_config_serial_in;
        next_s.cfg_s2  = s.cfg_s1;
        next_s.cs_s1   = i_cs_n;
        next_s.cs_s2   = s.cs_s1;
        next_s.cnv_s1  = i_conv_start;
        next_s.cnv_s2  = s.cnv_s1;
        next_s.cnv_d   = s.cnv_s2;
        next_s.mode_s1 = i_lvds_mode;
        next_s.mode_s2 = s.mode_s1;

        // word handed to the buffer; a stall keeps it pending
        if (s.word_pend && buf_ready) begin
            next_s.word_pend = 1'b0;
        end

        // shift in config bits; each full group of 12 is a word
        if (cfg_edge) begin
            next_s.shreg = word_now;
            if (s.bit_cnt == `RSP_WORD_LAST) begin  // R5 R7 R8
                next_s.bit_cnt = 4'h0;
                if (word_now != 12'h000) begin  // R6
                    next_s.word      = word_now;
                    next_s.word_pend = 1'b1;
                end
            end else begin
                next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
        end

        // buffered word takes effect right away
        if (pop_valid && pop_ready) begin
            next_s.range_cfg = pop_data;  // R2
        end

        // output shifter walks the packets of channels 0..3 in a ring
        if (out_edge) begin
            if (s.out_bit == 5'h00) begin
                next_s.out_bit = `RSP_PKT_LAST;
                next_s.out_ch  = s.out_ch + 2'h1;  // R20
            end else begin
                next_s.out_bit = s.out_bit - 5'h01;
            end
            next_s.echo = s.mode_s2 ? s.clk_s2 : ~s.echo;  // R14
        end

        unique case (s.phase)
            PH_STARTUP: begin
                if (s.timer == 20'h00000) begin
                    next_s.phase   = PH_WINDOW;  // R10
                    next_s.win     = 1'b1;
                    next_s.bit_cnt = 4'h0;  // R25
                end else begin
                    next_s.timer = s.timer - 20'h00001;
                end
            end
            PH_WINDOW: begin
                if (cnv_edge) begin
                    next_s.phase      = PH_CONVERT;
                    next_s.busy       = 1'b1;
                    next_s.win        = 1'b0;
                    next_s.bit_cnt    = 4'h0;  // R4
                    next_s.conv_range = next_s.range_cfg;
                    next_s.timer      = conv_cycles(enables(
                                            next_s.range_cfg));  // R3
                end
            end
            PH_CONVERT: begin
                if (s.timer == 20'h00000) begin
                    next_s.phase   = PH_WINDOW;
                    next_s.busy    = 1'b0;  // R10
                    next_s.win     = 1'b1;
                    next_s.bit_cnt = 4'h0;  // R25
                    // newest results, channel 0 first, echo forced low
                    next_s.results = i_results;  // R13
                    next_s.out_ch  = 2'h0;
                    next_s.out_bit = `RSP_PKT_LAST;
                    next_s.echo    = 1'b0;
                end else begin
                    next_s.timer = s.timer - 20'h00001;
                end
            end
        endcase

        next_s.ch_en   = enables(next_s.range_cfg);  // R3
        next_s.result_serial_out     = pkt_bit(next_s.results, next_s.out_ch,
                                 next_s.conv_range, next_s.out_bit);
        // pins released while chip select is high
        next_s.sdo_oe  = ~s.cs_s2;  // R17
        next_s.echo_oe = ~s.cs_s2;  // R17
    end

    // state register; reset restores code 7 and clears results
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s            <= '0;
            s.phase      <= PH_STARTUP;
            s.timer      <= 20'(STARTUP_CYCLES);
            s.range_cfg  <= `RSP_CFG_RESET;  // R1
            s.conv_range <= `RSP_CFG_RESET;
            s.ch_en      <= 4'hF;
            s.out_bit    <= `RSP_PKT_LAST;
            s.cs_s1      <= 1'b1;
            s.cs_s2      <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign o_result_serial_out  = s.result_serial_out;
    assign o_result_serial_oe   = s.sdo_oe;
    assign o_echoed_clock_out   = s.echo;
    assign o_echoed_clock_oe    = s.echo_oe;
    assign o_busy               = s.busy;
    assign o_input_range_select = s.range_cfg;
    assign o_ch_enable          = s.ch_en;
    assign o_window_open        = s.win;

    // checks on the port's own behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence conv_go;
        s.phase == PH_WINDOW && cnv_edge;
    endsequence

    sequence conv_end;
        s.phase == PH_CONVERT && s.timer == 20'h00000;
    endsequence

    chk_reset_range: assert property ( // R1
        !$past(i_nrst) |-> o_input_range_select == 12'hFFF)
        else $error("range register not all ones after reset");

    chk_never_zero: assert property ( // R6
        o_input_range_select != 12'h000)
        else $error("all-zero range word was loaded");

    chk_word_push: assert property ( // R5
        cfg_edge && s.bit_cnt == 4'hB && word_now != 12'h000
        |=> s.word_pend && s.word == $past(word_now))
        else $error("complete word not handed on");

    chk_partial_drop: assert property ( // R4
        conv_go |=> s.bit_cnt == 4'h0 && !s.win && o_busy)
        else $error("partial word survived window close");

    chk_window_open: assert property ( // R10
        conv_end |=> o_window_open && !o_busy && s.bit_cnt == 4'h0)
        else $error("window did not open as busy fell");

    chk_load_ch0: assert property ( // R13
        conv_end |=> s.out_ch == 2'h0 && s.out_bit == 5'h17
                     && s.results == $past(i_results))
        else $error("output not loaded with channel 0");

    chk_ch_wrap: assert property ( // R20
        out_edge && !(s.phase == PH_CONVERT && s.timer == 20'h00000)
        && s.out_bit == 5'h00 && s.out_ch == 2'h3
        |=> s.out_ch == 2'h0 && s.out_bit == 5'h17)
        else $error("packet ring did not wrap to channel 0");

    chk_cs_release: assert property ( // R17
        s.cs_s2 |=> !o_result_serial_oe && !o_echoed_clock_oe)
        else $error("outputs driven with chip select high");

    chk_chan_off: assert property ( // R3
        o_ch_enable[0] == (o_input_range_select[2:0] != 3'h0)
        && o_ch_enable[3] == (o_input_range_select[11:9] != 3'h0))
        else $error("channel enable does not follow code 000");

    chk_cmos_fall: assert property ( // R23
        !s.mode_s2 && fall && s.phase == PH_WINDOW && !cnv_edge
        |=> $stable(s.bit_cnt))
        else $error("falling edge sampled in CMOS mode");

endmodule : rsp_serial_port

// ---- verification/rsp_host_model.sv ----
`timescale 1ns/1ns

// host side: drives shift clock, config data, select and start
module rsp_host_model (
    // system clock for pacing
    input  wire logic i_clk,
    // pins towards the port
    output logic      o_sck,
    output logic      o_cfg,
    output logic      o_cs_n,
    output logic      o_conv,
    // pins from the port
    input  wire logic i_sdo,
    input  wire logic i_echo,
    input  wire logic i_oe,
    input  wire logic i_busy,
    input  wire logic i_lvds
);
    // idle: clock low, data low, deselected
    initial begin
        o_sck  = 1'b0;
        o_cfg  = 1'b0;
        o_cs_n = 1'b1;
        o_conv = 1'b0;
    end

    // pace by falling edges of the system clock
    task automatic wn(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wn

    // frame of n shifting edges; din and cap are msb first
    task automatic frame(input int n, input logic [95:0] din,
                         output logic [95:0] cap, output logic bad);
        int s;
        s = 0;
        cap = '0;
        bad = 1'b0;
        wn(1);
        o_cs_n = 1'b0;
        wn(4);
        while (s < n) begin
            if (i_lvds || !o_sck) begin
                // data moves mid-phase so the synchroniser sees it settled
                wn(2);
                o_cfg = din[95-s];
                wn(2);
                // a released pin reads as the inverse, so it cannot pass
                cap[95-s] = i_oe ? i_sdo : !i_sdo;
                if (i_oe !== 1'b1 || (i_lvds && i_echo !== o_sck))
                    bad = 1'b1;
                s++;
            end else begin
                wn(4);
            end
            o_sck = !o_sck;
        end
        // end low so select never moves with the clock high
        wn(4);
        o_sck = 1'b0;
        o_cfg = 1'b0;
        wn(4);
        o_cs_n = 1'b1;
        wn(4);
    endtask : frame

    // pulse the start pin and time busy in system clock cycles
    task automatic convert(output int dur);
        int t;
        dur = -1;
        wn(1);
        o_conv = 1'b1;
        for (t = 0; t < 10 && i_busy !== 1'b1; t++)
            wn(1);
        o_conv = 1'b0;
        for (t = 0; t < 400 && i_busy === 1'b1; t++)
            wn(1);
        if (i_busy === 1'b0)
            dur = t;
        wn(4);
    endtask : convert
endmodule : rsp_host_model

// ---- verification/adc_range_config_serial_port_bench.sv ----
`timescale 1ns/1ns
`include "rsp_params.svh"

module adc_range_config_serial_port_bench;
    // made-up results, one 16-bit value per channel
    localparam logic [63:0] RES   = 64'hC3A5_0F1E_7788_9ABC;
    localparam int          CHC   = `RSP_CONV_CH_NS * `RSP_CLK_MHZ / 1000;
    localparam int          SU    = 20;
    localparam int          LIMIT = 20000;

    logic        clk;
    logic        nrst;
    logic        sck;
    logic        cfg;
    logic        cs_n;
    logic        conv;
    logic        lvds;
    logic        result_serial_out;
    logic        sdo_oe;
    logic        echo;
    logic        echo_oe;
    logic        busy;
    logic [11:0] rng;
    logic [3:0]  ch_en;
    logic        win;
    logic [95:0] cap;
    logic        bad;
    int          fails;
    int          n_checks;
    int          cyc;
    int          d4;
    int          d2;
    int          dx;
    int          cnt;

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end

    // short startup so the run stays brief
    rsp_serial_port #(
        .STARTUP_CYCLES (SU)
    ) uut (
        .i_clk                (clk),
        .i_nrst               (nrst),
        .i_input_shift_clock  (sck),
        .i_config_serial_in   (cfg),
        .i_cs_n               (cs_n),
        .i_conv_start         (conv),
        .i_lvds_mode          (lvds),
        .o_result_serial_out  (result_serial_out),
        .o_result_serial_oe   (sdo_oe),
        .o_echoed_clock_out   (echo),
        .o_echoed_clock_oe    (echo_oe),
        .o_busy               (busy),
        .i_results            (RES),
        .o_input_range_select (rng),
        .o_ch_enable          (ch_en),
        .o_window_open        (win)
    );

    // far side of the link
    rsp_host_model host (
        .i_clk  (clk),
        .o_sck  (sck),
        .o_cfg  (cfg),
        .o_cs_n (cs_n),
        .o_conv (conv),
        .i_sdo  (result_serial_out),
        .i_echo (echo),
        .i_oe   (sdo_oe),
        .i_busy (busy),
        .i_lvds (lvds)
    );

    // first two packets after a conversion, channel 0 then 1
    function automatic logic [47:0] pkts(input logic [11:0] r);
        pkts = {RES[15:0], 3'b000, 2'd0, r[2:0],
                RES[31:16], 3'b000, 2'd1, r[5:3]};
    endfunction : pkts

    task automatic chk_val(input string nm, input logic [47:0] e,
                           input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_checks++;
        if (g != e) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cnt

    task automatic done_test(input string nm);
        $display("test %s finished, %0d mismatches so far", nm, fails);
    endtask : done_test

    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // a hung handshake must not stall the run forever
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            close_out();
        end
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        lvds = 1'b0;
        repeat (10) @(negedge clk);
        chk_val("range", 48'hFFF, 48'(rng));
        chk_val("enables", 48'hF, 48'(ch_en));
        chk_val("flags", 48'h0, {45'h0, busy, win, sdo_oe});
        nrst = 1'b1;
        cnt = 0;
        while (win !== 1'b1 && cnt < 100) begin
            @(negedge clk);
            cnt++;
        end
        chk_cnt("startup", SU + 1, cnt);
        done_test("reset");

        host.convert(d4);
        chk_val("window", 48'h1, 48'(win));
        // four packets so the ring wraps from channel 3 back to 0
        host.frame(96, '0, cap, bad);
        chk_val("packets", pkts(12'hFFF), cap[95:48]);
        chk_val("pins", 48'h0, {45'h0, bad, sdo_oe, echo_oe});
        chk_val("range", 48'hFFF, 48'(rng));
        done_test("cmos_idle");

        // two words and a trailing fragment in one frame
        host.frame(30, {12'hABC, 12'h143, 6'h3F, 66'h0}, cap, bad);
        chk_val("range", 48'h143, 48'(rng));
        chk_val("enables", 48'h5, 48'(ch_en));
        // conversion closes the window so the trailing fragment is dropped
        host.convert(d2);
        chk_cnt("busy_diff", 2 * CHC, d4 - d2);
        host.frame(11, {11'h7FF, 85'h0}, cap, bad);
        host.convert(dx);
        chk_val("range", 48'h143, 48'(rng));
        done_test("cmos_words");

        // leftover bits from the fragment would spoil this word
        host.frame(48, '0, cap, bad);
        chk_val("packets", pkts(12'h143), cap[95:48]);
        chk_val("range", 48'h143, 48'(rng));
        done_test("zero_word");

        // a word sent while busy must not land
        fork
            host.convert(dx);
            host.frame(12, {12'h777, 84'h0}, cap, bad);
        join
        chk_val("range", 48'h143, 48'(rng));
        host.convert(dx);
        done_test("busy_refuse");

        lvds = 1'b1;
        repeat (4) @(negedge clk);
        host.frame(48, {12'h9F1, 84'h0}, cap, bad);
        chk_val("range", 48'h9F1, 48'(rng));
        chk_val("packets", pkts(12'h143), cap[95:48]);
        chk_val("pins", 48'h0, {45'h0, bad, sdo_oe, echo_oe});
        done_test("lvds");
        close_out();
    end
endmodule : adc_range_config_serial_port_bench
